// >>> logic/adcst_pkg.sv
package adcst_pkg;
   // ---------------------------------------------------------------
   // Scan chain layout, bit 0 sits nearest the serial output
   // ---------------------------------------------------------------
   localparam int CHAIN_LEN = 28;
   localparam int DAC_W = 10;
   localparam int MUX_W = 8;
   localparam int POS_COMPARE = 0;
   localparam int POS_AMP_CLOCK = 1;
   localparam int POS_AMP_PATH = 2;
   localparam int POS_BG_COMP = 3;
   localparam int POS_CONV_POWER = 4;
   localparam int POS_AMP_POWER = 5;
   localparam int POS_DAC_LSB = 6;
   localparam int POS_BYPASS = 16;
   localparam int POS_GND = 17;
   localparam int POS_HOLD = 18;
   localparam int POS_IREF = 19;
   localparam int POS_MUX_LSB = 20;
   // Idle pattern: hold, bypass, DAC bit 9 and mux bit 0 high
   localparam logic [CHAIN_LEN-1:0] CHAIN_IDLE = 28'h0158000;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_APPLIED = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_SHIFT = 12'h00C;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   localparam int STAT_COMP_BIT = 0;
   localparam int STAT_CAPT_BIT = 1;
endpackage

// >>> logic/adcst_scan_controls.sv
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
module adcst_scan_controls #(
   parameter int SYNC_STAGES = 2
) (
   input wire logic ref_clk, // System clock, 20 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic tckPin, // Test clock from tester
   input wire logic tdiPin, // Serial data in
   input wire logic captureDrPin, // TAP in capture-DR with this chain selected
   input wire logic shiftDrPin, // TAP in shift-DR with this chain selected
   input wire logic updateDrPin, // TAP in update-DR with this chain selected
   output logic tdoPin, // Serial data out
   input wire logic comparatorIn, // Comparator result from analog side
   output logic ampClock, // Switched-cap amplifier clock
   output logic amplifier_path_enable, // Amplifier to comparator path
   output logic bandgap_to_comparator_enable, // Bandgap onto negative input
   output logic converter_power_enable, // Converter power on
   output logic amplifier_power_enable, // Amplifier power on
   output logic [adcst_pkg::DAC_W-1:0] dacCode, // DAC code, bit 9 MSB
   output logic bypass_channel_select, // Channels 0-3 bypass amplifier
   output logic negative_input_ground_enable, // Ground negative input
   output logic sampleHold, // Low samples, high holds
   output logic internal_reference_enable, // Bandgap as DAC reference
   output logic [adcst_pkg::MUX_W-1:0] inputMuxSelect, // Input mux, bit 0 is input_mux_select_bit0
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [adcst_pkg::ADDR_W-1:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr // APB error
);
   import adcst_pkg::*;

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (SYNC_STAGES < 2) begin : g_syncCheck
      $error("SYNC_STAGES must be at least 2");
   end
   if (CHAIN_LEN < POS_MUX_LSB + MUX_W) begin : g_chainCheck
      $error("Scan chain too short for its cells");
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] syncR [SYNC_STAGES];
   logic [NSYNC-1:0] pinsNow;
   logic tckPrev_r;
   logic tckRise, tckFall;
   logic tdiS, captureS, shiftS, updateS, compS;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            syncR[i] <= '0;
         end
      end else begin
         syncR[0] <= {comparatorIn, updateDrPin, shiftDrPin, captureDrPin, tdiPin, tckPin};
         for (int i = 1; i < SYNC_STAGES; i++) begin
            syncR[i] <= syncR[i-1];
         end
      end
   end

   assign pinsNow = syncR[SYNC_STAGES-1];
   assign tdiS = pinsNow[1];
   assign captureS = pinsNow[2];
   assign shiftS = pinsNow[3];
   assign updateS = pinsNow[4];
   assign compS = pinsNow[5];

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tckPrev_r <= 1'b0;
      end else begin
         tckPrev_r <= pinsNow[0];
      end
   end

   assign tckRise = pinsNow[0] & ~tckPrev_r;
   assign tckFall = ~pinsNow[0] & tckPrev_r;

   // ---------------------------------------------------------------
   // Shift stage, update latches and serial output
   // ---------------------------------------------------------------
   logic [CHAIN_LEN-1:0] shift_r;
   logic [CHAIN_LEN-1:0] applied_r;
   logic compCapt_r;
   logic tdo_r;
   logic ctrlEnable_r;

   // Observe cell takes the live comparator; control cells reflect what is applied
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= CHAIN_IDLE;
         compCapt_r <= 1'b0;
      end else if (tckRise && captureS) begin
         shift_r <= {applied_r[CHAIN_LEN-1:1], compS};
         compCapt_r <= compS;
      end else if (tckRise && shiftS) begin
         shift_r <= {tdiS, shift_r[CHAIN_LEN-1:1]};
      end
   end

   // Latches change only on update, so shifting never disturbs the converter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         applied_r <= CHAIN_IDLE;
      end else if (tckFall && updateS) begin
         applied_r <= {shift_r[CHAIN_LEN-1:1], 1'b0};
      end
   end

   // Output changes on falling test clock, tester samples on rising
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tdo_r <= 1'b0;
      end else if (tckFall) begin
         tdo_r <= shift_r[0];
      end
   end

   assign tdoPin = tdo_r;

   // ---------------------------------------------------------------
   // Analog control outputs
   // ---------------------------------------------------------------
   logic [CHAIN_LEN-1:0] driveVec;

   // Software disable parks every control at its safe idle value
   assign driveVec = ctrlEnable_r ? applied_r : CHAIN_IDLE;

   // Amplifier clock only moves as fast as the tester toggles its cell
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ampClock <= CHAIN_IDLE[POS_AMP_CLOCK];
      end else begin
         ampClock <= driveVec[POS_AMP_CLOCK];
      end
   end

   // Amplifier output onto the comparator
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         amplifier_path_enable <= CHAIN_IDLE[POS_AMP_PATH];
      end else begin
         amplifier_path_enable <= driveVec[POS_AMP_PATH];
      end
   end

   // Bandgap onto the negative input; contention is the tester's to avoid
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bandgap_to_comparator_enable <= CHAIN_IDLE[POS_BG_COMP];
      end else begin
         bandgap_to_comparator_enable <= driveVec[POS_BG_COMP];
      end
   end

   // Converter power
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_power_enable <= CHAIN_IDLE[POS_CONV_POWER];
      end else begin
         converter_power_enable <= driveVec[POS_CONV_POWER];
      end
   end

   // Amplifier power
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         amplifier_power_enable <= CHAIN_IDLE[POS_AMP_POWER];
      end else begin
         amplifier_power_enable <= driveVec[POS_AMP_POWER];
      end
   end

   // DAC code moves as one word, never bit by bit
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dacCode <= CHAIN_IDLE[POS_DAC_LSB +: DAC_W];
      end else begin
         dacCode <= driveVec[POS_DAC_LSB +: DAC_W];
      end
   end

   // Channel bypass around the amplifier
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bypass_channel_select <= CHAIN_IDLE[POS_BYPASS];
      end else begin
         bypass_channel_select <= driveVec[POS_BYPASS];
      end
   end

   // Negative input to ground
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         negative_input_ground_enable <= CHAIN_IDLE[POS_GND];
      end else begin
         negative_input_ground_enable <= driveVec[POS_GND];
      end
   end

   // Hold idles high so reset never leaves the converter tracking
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sampleHold <= CHAIN_IDLE[POS_HOLD];
      end else begin
         sampleHold <= driveVec[POS_HOLD];
      end
   end

   // Bandgap as DAC reference
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         internal_reference_enable <= CHAIN_IDLE[POS_IREF];
      end else begin
         internal_reference_enable <= driveVec[POS_IREF];
      end
   end

   // Input mux select
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         inputMuxSelect <= CHAIN_IDLE[POS_MUX_LSB +: MUX_W];
      end else begin
         inputMuxSelect <= driveVec[POS_MUX_LSB +: MUX_W];
      end
   end

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // Register select, shared by the write and read decoders
   function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] regAddr);
      return addr == regAddr;
   endfunction

   logic setupPhase, accessDone;
   logic [31:0] rdata_r;
   logic err_r;

   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlEnable_r <= CTRL_ENABLE_RESET;
      end else if (accessDone && pwrite && regHit(paddr, ADDR_CTRL)) begin
         ctrlEnable_r <= pwdata[CTRL_ENABLE_BIT];
      end
   end

   // Read data is prepared during setup so the access phase needs no wait
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= '0;
         err_r <= 1'b0;
      end else if (setupPhase) begin
         rdata_r <= '0;
         err_r <= 1'b0;
         if (regHit(paddr, ADDR_CTRL)) begin
            rdata_r[CTRL_ENABLE_BIT] <= ctrlEnable_r;
         end else if (regHit(paddr, ADDR_APPLIED)) begin
            rdata_r[CHAIN_LEN-1:0] <= applied_r;
         end else if (regHit(paddr, ADDR_STATUS)) begin
            rdata_r[STAT_COMP_BIT] <= compS;
            rdata_r[STAT_CAPT_BIT] <= compCapt_r;
         end else if (regHit(paddr, ADDR_SHIFT)) begin
            rdata_r[CHAIN_LEN-1:0] <= shift_r;
         end else begin
            err_r <= 1'b1;
         end
      end
   end

   assign pready = 1'b1;
   assign prdata = rdata_r;
   assign pslverr = err_r & accessDone;
endmodule // adcst_scan_controls

// >>> verification/adcst_scan_controls_asserts.sv
`timescale 1ns/100ps
module adcst_scan_controls_asserts (
   input wire logic ref_clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic updateDrPin, // Update
   input wire logic psel, // Select
   input wire logic sampleHold, // Hold
   input wire logic bypass_channel_select, // Bypass
   input wire logic [adcst_pkg::DAC_W-1:0] dacCode, // DAC
   input wire logic converter_power_enable, // Power
   input wire logic amplifier_power_enable, // Power
   input wire logic negative_input_ground_enable, // Ground
   input wire logic bandgap_to_comparator_enable, // Bandgap
   input wire logic internal_reference_enable, // Reference
   input wire logic amplifier_path_enable // Path
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_hold_idle; $rose(rst_n) |-> sampleHold; endproperty
   a_hold_idle: assert property (p_hold_idle) else $error("hold not idle");
   property p_byp_idle; $rose(rst_n) |-> bypass_channel_select; endproperty
   a_byp_idle: assert property (p_byp_idle) else $error("bypass not idle");
   property p_dac_idle; $rose(rst_n) |-> dacCode == 10'h200; endproperty
   a_dac_idle: assert property (p_dac_idle) else $error("dac not idle");
   property p_pwr_idle; $rose(rst_n) |-> !(converter_power_enable || amplifier_power_enable); endproperty
   a_pwr_idle: assert property (p_pwr_idle) else $error("power not idle");
   property p_gnd_idle; $rose(rst_n) |-> !negative_input_ground_enable; endproperty
   a_gnd_idle: assert property (p_gnd_idle) else $error("ground not idle");
   property p_ref_idle;
      $rose(rst_n) |-> !(bandgap_to_comparator_enable || internal_reference_enable || amplifier_path_enable);
   endproperty
   a_ref_idle: assert property (p_ref_idle) else $error("refs not idle");
   // Controls move only after an update step or a register write
   property p_dac_stable; (!updateDrPin && !psel)[*8] |=> $stable(dacCode); endproperty
   a_dac_stable: assert property (p_dac_stable) else $error("dac moved");
   property p_hold_stable; (!updateDrPin && !psel)[*8] |=> $stable(sampleHold); endproperty
   a_hold_stable: assert property (p_hold_stable) else $error("hold moved");
endmodule // adcst_scan_controls_asserts

bind adcst_scan_controls adcst_scan_controls_asserts chk (.ref_clk, .rst_n, .updateDrPin, .psel, .sampleHold,
   .bypass_channel_select, .dacCode, .converter_power_enable, .amplifier_power_enable,
   .negative_input_ground_enable, .bandgap_to_comparator_enable, .internal_reference_enable,
   .amplifier_path_enable);

// >>> verification/adcst_scan_tester.sv
`timescale 1ns/100ps
module adcst_scan_tester (
   output logic tckPin, // Test clock
   output logic tdiPin, // Serial in
   output logic captureDrPin, // Capture
   output logic shiftDrPin, // Shift
   output logic updateDrPin, // Update
   input wire logic tdoPin // Serial out
);
   initial begin
      {tckPin, tdiPin, captureDrPin, shiftDrPin, updateDrPin} = 5'h00;
   end
   // Pins move mid-low so no tck edge sees them change
   task automatic scan(input logic [27:0] din, output logic [27:0] dout);
      #113 captureDrPin = 1'b1;
      #200 tckPin = 1'b1;
      #200 tckPin = 1'b0;
      #100 captureDrPin = 1'b0;
      shiftDrPin = 1'b1;
      for (int i = 0; i < 28; i++) begin
         tdiPin = din[i];
         #100 dout[i] = tdoPin;
         tckPin = 1'b1;
         #200 tckPin = 1'b0;
         #100;
      end
      shiftDrPin = 1'b0;
      updateDrPin = 1'b1;
      #100 tckPin = 1'b1;
      #200 tckPin = 1'b0;
      #400 updateDrPin = 1'b0;
      tdiPin = ~tdiPin;
   endtask
endmodule // adcst_scan_tester

// >>> verification/adcst_scan_controls_test.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin checkCount++; if ((a) !== (e)) begin numErrors++; \
   $display("wrong value %s expected %h seen %h", n, e, a); end end
module adcst_scan_controls_test;
   import adcst_pkg::*;
   // ----
   // Patterns: A uses the amplifier while sampling, B and C are limit checks
   // ----
   localparam logic [27:0] IDLE = 28'h0158000;
   localparam logic [27:0] PAT_A = 28'h08A8036;
   localparam logic [27:0] PAT_B = 28'h01548D8;
   localparam logic [27:0] PAT_C = 28'h01550D8;
   logic ref_clk, rst_n, psel, penable, pwrite, comparatorIn, pready, pslverr, e;
   logic tck, tdi, cap, sft, upd, tdo;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [27:0] dout;
   wire [27:0] ctl;
   int numErrors, checkCount;
   assign ctl[0] = 1'b0;
   adcst_scan_controls uut (.ref_clk(ref_clk), .rst_n(rst_n), .tckPin(tck), .tdiPin(tdi), .captureDrPin(cap),
      .shiftDrPin(sft), .updateDrPin(upd), .tdoPin(tdo), .comparatorIn(comparatorIn), .ampClock(ctl[1]),
      .amplifier_path_enable(ctl[2]), .bandgap_to_comparator_enable(ctl[3]), .converter_power_enable(ctl[4]),
      .amplifier_power_enable(ctl[5]), .dacCode(ctl[15:6]), .bypass_channel_select(ctl[16]),
      .negative_input_ground_enable(ctl[17]), .sampleHold(ctl[18]), .internal_reference_enable(ctl[19]),
      .inputMuxSelect(ctl[27:20]), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   adcst_scan_tester tester (.tckPin(tck), .tdiPin(tdi), .captureDrPin(cap), .shiftDrPin(sft),
      .updateDrPin(upd), .tdoPin(tdo));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      `CHK("rdata", x, q)
      `CHK("pslverr", xe, e)
   endtask
   task automatic finishTest();
      $display("checks %0d mismatches %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      numErrors++;
      finishTest();
   end
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, comparatorIn} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      `CHK("idle", IDLE, ctl)
      rd(ADDR_CTRL, 32'h1, 1'b0);
      $display("reset test done");
      tester.scan(PAT_A, dout);
      `CHK("captured", IDLE, dout)
      `CHK("controls", PAT_A, ctl)
      rd(ADDR_APPLIED, {4'h0, PAT_A}, 1'b0);
      tester.scan(PAT_B, dout);
      `CHK("captured", PAT_A, dout)
      `CHK("controls", PAT_B, ctl)
      @(posedge ref_clk) comparatorIn <= 1'b1;
      tester.scan(PAT_C, dout);
      `CHK("captured", PAT_B | 28'h1, dout)
      `CHK("controls", PAT_C, ctl)
      rd(ADDR_STATUS, 32'h3, 1'b0);
      $display("scan test done");
      apb(1'b1, ADDR_CTRL, 32'h0);
      repeat (3) @(posedge ref_clk);
      `CHK("disabled", IDLE, ctl)
      apb(1'b1, ADDR_CTRL, 32'h1);
      repeat (3) @(posedge ref_clk);
      `CHK("enabled", PAT_C, ctl)
      rd(12'h010, 32'h0, 1'b1);
      $display("register test done");
      finishTest();
   end
endmodule // adcst_scan_controls_test
